//--- rtl/sar_adc_consts.vh
// Constants of the converter control block: register indices, fields,
// reset values and conversion timing.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_CONTROL       10'h084
`define IDX_SELECT        10'h085
`define IDX_RESULT_HIGH   10'h086
`define IDX_IRQ_ENABLE    10'h087
`define IDX_CHEN_GROUP0   10'h0ec
`define IDX_CHEN_GROUP3   10'h0ef

// Control register fields
`define CTL_ENABLE_BIT    7
`define CTL_REQUEST_BIT   6
`define CTL_DONE_BIT      5
`define CTL_FLAG_BIT      4

// Select register fields
`define SEL_DIV_MSB       7
`define SEL_DIV_LSB       5
`define SEL_CH_MSB        4
`define SEL_CH_LSB        0

// Reset values
`define RST_SELECT        8'h00
`define RST_RESULT        10'h000
`define RST_CHEN          8'hff

// Conversion timing in conversion clock cycles
`define SETUP_CYCLES      7'h08
`define CYCLES_PER_BIT    7'h08
`define RESULT_BITS       7'h0a
`define HOLD_CYCLES       7'h08
`define CONV_CYCLES       (`SETUP_CYCLES + `CYCLES_PER_BIT * `RESULT_BITS + `HOLD_CYCLES)
`define CONV_LAST         7'h5f

// Bus answers
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

//--- rtl/conv_clock_div.v
// Conversion clock divider: a one-cycle enable pulse every 2^(code+1)
// system clocks. Assumes restart is a same-domain pulse at conversion start.
`timescale 1ns/1ns
module conv_clock_div (
	// Clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// Control
	input  wire       restart,
	input  wire [2:0] div_code,
	// Enable pulse
	output reg        tick
);
	reg  [7:0] count_reg;
	wire [7:0] last;

	// Division by 2,4,...,256 ends the count at 2^(code+1)-1
	assign last = (8'h02 << div_code) - 8'h01;

	// Restart aligns the first tick to a full period after start
	always @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= 8'h00;
			tick      <= 1'b0;
		end else if (restart) begin
			count_reg <= 8'h00;
			tick      <= 1'b0;
		end else if (count_reg == last) begin
			count_reg <= 8'h00;
			tick      <= 1'b1;
		end else begin
			count_reg <= count_reg + 8'h01;
			tick      <= 1'b0;
		end
	end
endmodule // conv_clock_div

//--- rtl/sar_adc_ctrl.v
// Successive-approximation converter control with an AXI4-Lite register
// slave. Assumes an external comparator, resistor-tree DAC and input mux;
// the comparator output is asynchronous and is synchronised here.
//
// Functional notes
// - Divider code selects system clock over 2..256
// - Channel code: group in top bits, pin below
// - Start needs enable and request both set
// - Approximation bits cleared at start, updated per step
// - Ten-bit result, one channel per conversion
// - Completion sets done bit and interrupt flag
// - Completion clears request bit by hardware
// - Result high byte plus low two control bits
// - Conversion lasts exactly 96 conversion clocks
// - Setup 8, ten bits of 8, hold 8
// - First trial code is half scale
// - Done reads zero running, one idle, resets one
// - Interrupt request when flag set and enabled
`timescale 1ns/1ns
`include "sar_adc_consts.vh"
module sar_adc_ctrl (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [11:0] s_axi_awaddr,
	// AXI4-Lite write data
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	// AXI4-Lite read address
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	input  wire [11:0] s_axi_araddr,
	// AXI4-Lite read data
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	// Analog side
	input  wire        comp_above,
	output reg  [9:0]  dac_code,
	output reg  [4:0]  mux_channel,
	output reg  [31:0] channel_on,
	output reg         sample_active,
	// Interrupt request
	output reg         conv_irq
);
	// Sequencer states
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	// Software visible state
	reg        enable_reg;
	reg        request_reg;
	reg        done_reg;
	reg        flag_reg;
	reg        irq_en_reg;
	reg  [7:0] select_reg;
	reg  [9:0] result_reg;
	reg  [7:0] chen_n_reg [0:3];

	// Conversion state
	reg        state_reg;
	reg  [6:0] step_reg;
	reg  [9:0] approximation_bits;
	reg  [2:0] div_cap_reg;
	reg  [4:0] ch_cap_reg;
	reg        comp_meta_reg;
	reg        comp_sync_reg;

	// Bus holding state
	reg        aw_held_reg;
	reg        w_held_reg;
	reg  [9:0] aw_idx_reg;
	reg  [7:0] wdata_reg;
	reg        wlane_reg;

	wire       tick;
	wire       start;
	wire       finish;
	wire       do_write;
	wire [9:0] ar_idx;
	wire [3:0] bit_pos;
	wire       in_bits;
	wire       bit_end;

	// Index of a byte address; the low two bits select nothing
	function [9:0] reg_index;
		input [11:0] addr;
		begin
			reg_index = addr[11:2];
		end
	endfunction

	// Whether an index names a register of this block
	function mapped;
		input [9:0] idx;
		begin
			mapped = (idx == `IDX_CONTROL) || (idx == `IDX_SELECT) ||
				(idx == `IDX_RESULT_HIGH) || (idx == `IDX_IRQ_ENABLE) ||
				((idx >= `IDX_CHEN_GROUP0) && (idx <= `IDX_CHEN_GROUP3));
		end
	endfunction

	// Result bit decided in a given step of the bit phase, MSB first
	function [3:0] step_bit;
		input [6:0] step;
		reg   [6:0] rel;
		begin
			rel      = step - `SETUP_CYCLES;
			step_bit = 4'h9 - rel[6:3];
		end
	endfunction

	// Conversion clock enable from the captured divider code
	conv_clock_div u_div (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.restart  (start),
		.div_code (div_cap_reg),
		.tick     (tick)
	);

	// Comparator is asynchronous to aclk, so two flops before any use
	always @(posedge aclk) begin
		if (!aresetn) begin
			comp_meta_reg <= 1'b0;
			comp_sync_reg <= 1'b0;
		end else begin
			comp_meta_reg <= comp_above;
			comp_sync_reg <= comp_meta_reg;
		end
	end

	// Start only from idle; a request seen while running does nothing
	assign start  = (state_reg == ST_IDLE) && enable_reg && request_reg;
	assign finish = (state_reg == ST_RUN) && tick && (step_reg == `CONV_LAST);

	// Phase decode of the step counter
	assign in_bits = (step_reg >= `SETUP_CYCLES) &&
		(step_reg < (`SETUP_CYCLES + `CYCLES_PER_BIT * `RESULT_BITS));
	assign bit_end = in_bits && (step_reg[2:0] == 3'h7);
	assign bit_pos = step_bit(step_reg);

	// Sequencer: 96 ticks, then back to idle
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_reg   <= ST_IDLE;
			step_reg    <= 7'h00;
			div_cap_reg <= 3'h0;
			ch_cap_reg  <= 5'h00;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start) begin
						state_reg   <= ST_RUN;
						step_reg    <= 7'h00;
						div_cap_reg <= select_reg[`SEL_DIV_MSB:`SEL_DIV_LSB];
						ch_cap_reg  <= select_reg[`SEL_CH_MSB:`SEL_CH_LSB];
					end
				end
				ST_RUN: begin
					if (finish) begin
						state_reg <= ST_IDLE;
						step_reg  <= 7'h00;
					end else if (tick) begin
						step_reg <= step_reg + 7'h01;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Successive approximation: trial bit set, then kept or cleared
	always @(posedge aclk) begin
		if (!aresetn) begin
			approximation_bits <= `RST_RESULT;
		end else if (start) begin
			approximation_bits <= `RST_RESULT;
		end else if ((state_reg == ST_RUN) && tick) begin
			if (step_reg == (`SETUP_CYCLES - 7'h01)) begin
				approximation_bits <= 10'h200;
			end else if (bit_end) begin
				// Decide this bit and place the next trial bit below it
				if (!comp_sync_reg)
					approximation_bits[bit_pos] <= 1'b0;
				if (bit_pos != 4'h0)
					approximation_bits[bit_pos - 4'h1] <= 1'b1;
			end
		end
	end

	// Analog side drive; the channel is steered only while converting
	always @(posedge aclk) begin
		if (!aresetn) begin
			dac_code      <= 10'h000;
			mux_channel   <= 5'h00;
			channel_on    <= 32'h00000000;
			sample_active <= 1'b0;
		end else begin
			dac_code      <= approximation_bits;
			mux_channel   <= ch_cap_reg;
			sample_active <= (state_reg == ST_RUN);
			// Group from the top two bits, pin from the low three
			channel_on    <= 32'h00000000;
			if (state_reg == ST_RUN)
				channel_on[ch_cap_reg] <=
					~chen_n_reg[ch_cap_reg[4:3]][ch_cap_reg[2:0]];
		end
	end

	// Status, result and request handling
	always @(posedge aclk) begin
		if (!aresetn) begin
			done_reg    <= 1'b1;
			flag_reg    <= 1'b0;
			request_reg <= 1'b0;
			result_reg  <= `RST_RESULT;
		end else begin
			if (start)
				done_reg <= 1'b0;
			else if (finish)
				done_reg <= 1'b1;
			// Hardware set wins over a software clear in the same cycle
			if (finish)
				flag_reg <= 1'b1;
			else if (do_write && wlane_reg && (aw_idx_reg == `IDX_CONTROL))
				flag_reg <= wdata_reg[`CTL_FLAG_BIT];
			// Completion clears the request even if software writes it
			if (finish)
				request_reg <= 1'b0;
			else if (do_write && wlane_reg && (aw_idx_reg == `IDX_CONTROL))
				request_reg <= wdata_reg[`CTL_REQUEST_BIT];
			// Previous result is overwritten only at completion
			if (finish)
				result_reg <= approximation_bits;
		end
	end

	// Interrupt request follows the sticky flag gated by its enable
	always @(posedge aclk) begin
		if (!aresetn)
			conv_irq <= 1'b0;
		else
			conv_irq <= flag_reg && irq_en_reg;
	end

	// Write channels are taken independently and held until both arrive
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			aw_idx_reg   <= 10'h000;
			wdata_reg    <= 8'h00;
			wlane_reg    <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_idx_reg  <= reg_index(s_axi_awaddr);
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata[7:0];
				wlane_reg  <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(aw_idx_reg) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register writes; only byte lane 0 carries register data
	always @(posedge aclk) begin
		if (!aresetn) begin
			enable_reg    <= 1'b0;
			irq_en_reg    <= 1'b0;
			select_reg    <= `RST_SELECT;
			chen_n_reg[0] <= `RST_CHEN;
			chen_n_reg[1] <= `RST_CHEN;
			chen_n_reg[2] <= `RST_CHEN;
			chen_n_reg[3] <= `RST_CHEN;
		end else if (do_write && wlane_reg) begin
			case (aw_idx_reg)
				`IDX_CONTROL:    enable_reg <= wdata_reg[`CTL_ENABLE_BIT];
				`IDX_SELECT:     select_reg <= wdata_reg;
				`IDX_IRQ_ENABLE: irq_en_reg <= wdata_reg[0];
				default: begin
					if ((aw_idx_reg >= `IDX_CHEN_GROUP0) && (aw_idx_reg <= `IDX_CHEN_GROUP3))
						chen_n_reg[aw_idx_reg[1:0]] <= wdata_reg;
				end
			endcase
		end
	end

	// Read path: one cycle from address to data, held until taken
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_idx        = reg_index(s_axi_araddr);

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
			s_axi_rdata  <= 32'h00000000;
			case (ar_idx)
				`IDX_CONTROL:
					s_axi_rdata[7:0] <= {enable_reg, request_reg, done_reg, flag_reg,
						2'b00, result_reg[1:0]};
				`IDX_SELECT:      s_axi_rdata[7:0] <= select_reg;
				`IDX_RESULT_HIGH: s_axi_rdata[7:0] <= result_reg[9:2];
				`IDX_IRQ_ENABLE:  s_axi_rdata[0]   <= irq_en_reg;
				default: begin
					if ((ar_idx >= `IDX_CHEN_GROUP0) && (ar_idx <= `IDX_CHEN_GROUP3))
						s_axi_rdata[7:0] <= chen_n_reg[ar_idx[1:0]];
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // sar_adc_ctrl

//--- bench/sar_adc_ctrl_props.sv
// Port checker of the converter control: run timing, decode and bus answers.
// Assumes it is bound to sar_adc_ctrl and sees only that module's ports.
`timescale 1ns/1ns
module sar_adc_ctrl_props (
	// Clock and reset
	input wire        aclk,
	input wire        aresetn,
	// Bus handshakes
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	// Analog side
	input wire [9:0]  dac_code,
	input wire [4:0]  mux_channel,
	input wire [31:0] channel_on,
	input wire        sample_active
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_start;
		$rose(sample_active);
	endsequence
	// Run length in system clocks; one clock of slack for the start edge
	logic [15:0] run_reg;
	always @(posedge aclk) begin
		run_reg <= (!aresetn || !sample_active) ? 16'h0000 : run_reg + 16'h0001;
	end
	wire [15:0] q = (run_reg % 96 == 1) ? run_reg - 16'h0001 : run_reg;
	wire [15:0] m = q / 96;
	AST_SETUP_CLEAR: assert property (s_start |-> (dac_code == 10'h000) [*8])
		else $error("approximation not clear during setup");
	AST_RUN_LENGTH: assert property ($fell(sample_active) |-> q % 96 == 0 && m >= 2 && (m & (m - 16'h1)) == 0)
		else $error("run length is not 96 divided clocks");
	AST_FIRST_TRIAL: assert property (sample_active && $past(dac_code) == 10'h000 && dac_code != 10'h000 |-> dac_code == 10'h200)
		else $error("first trial code is not half scale");
	AST_ONE_CHANNEL: assert property ($onehot0(channel_on))
		else $error("more than one input switched on");
	AST_DECODE: assert property (channel_on != 32'h0 |-> channel_on == 32'h1 << mux_channel)
		else $error("switched input does not match channel code");
	AST_HOLD_CHANNEL: assert property (sample_active && $past(sample_active) |-> $stable(mux_channel))
		else $error("channel changed during a run");
	// Both halves are held for one cycle before the answer is raised
	AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule // sar_adc_ctrl_props

bind sar_adc_ctrl sar_adc_ctrl_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.dac_code, .mux_channel, .channel_on, .sample_active);

//--- bench/analog_front_model.sv
// Behavioural comparator, resistor tree and input switch.
// Assumes the bench holds the pin voltage, as a code, steady during a run.
`timescale 1ns/1ns
module analog_front_model (
	// From the control block
	input wire [9:0]  dac_code,
	input wire [31:0] channel_on,
	// Voltage of the pin under test
	input wire [9:0]  level,
	// To the control block
	output logic      comp_above
);
	// A pin left switched off floats to ground, so only a zero trial passes
	always_comb begin
		comp_above = (channel_on != 32'h0) ? (level >= dac_code) : (dac_code == 10'h000);
	end
endmodule // analog_front_model

//--- bench/sar_adc_ctrl_bench.sv
// Bench of the converter control: bus tasks, reset values and conversions.
// Assumes the comparator model on the analog side and a 25 MHz clock.
`timescale 1ns/1ns
`include "sar_adc_consts.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module sar_adc_ctrl_bench;
	localparam logic [11:0] a_ctl = {`IDX_CONTROL, 2'b00};
	localparam logic [11:0] a_sel = {`IDX_SELECT, 2'b00};
	localparam logic [11:0] a_res = {`IDX_RESULT_HIGH, 2'b00};
	localparam logic [11:0] a_irq = {`IDX_IRQ_ENABLE, 2'b00};
	localparam logic [11:0] a_ch0 = {`IDX_CHEN_GROUP0, 2'b00};
	logic        aclk = 0, aresetn = 0, comp_above;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         sample_active, conv_irq;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata, channel_on;
	wire  [9:0]  dac_code;
	wire  [4:0]  mux_channel;
	logic [9:0]  level = 0;
	logic [31:0] rd_v;
	logic [1:0]  rd_r, wr_r;
	int          bad_count = 0, n_tests = 0;
	logic [11:0] ra [9] = '{12'h210, 12'h214, 12'h218, 12'h21c, 12'h3b0, 12'h3b4, 12'h3b8,
		12'h3bc, 12'h220};
	logic [7:0]  rv [9] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
	logic [9:0]  lv [8] = '{10'h000, 10'h3ff, 10'h200, 10'h1ff, 10'h155, 10'h2aa, 10'h001, 10'h3fe};

	sar_adc_ctrl u_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .comp_above, .dac_code, .mux_channel, .channel_on,
		.sample_active, .conv_irq);
	analog_front_model u_front (.dac_code, .channel_on, .level, .comp_above);

	// Clock; the watchdog covers every wait on the design
	initial begin
		forever #20 aclk = ~aclk;
	end
	initial begin
		#3000000;
		bad_count++;
		end_of_test;
	end

	// Handshakes are judged at the falling edge, when nothing is changing
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic ta, tw, tb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			wr_r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
		end while (!tb);
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [11:0] a);
		logic ta, tr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			rd_v = s_axi_rdata;
			rd_r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 0;
		end while (!tr);
		s_axi_rready <= 0;
	endtask

	// One conversion; mid also rewrites select and request while running
	task automatic conv(input logic [2:0] c, input logic [4:0] ch, input logic [9:0] lvl,
		input logic en, input logic mid);
		logic [11:0] ga;
		logic [9:0]  ex;
		ga = a_ch0 + {8'h0, ch[4:3], 2'b00};
		ex = en ? lvl : 10'h000;
		level <= lvl;
		wr(ga, en ? ~(8'h01 << ch[2:0]) : 8'hff);
		wr(a_sel, {c, ch});
		wr(a_ctl, 8'hc0);
		rd(a_ctl);
		`CHK(rd_v[5], 1'b0)
		if (mid) begin
			wr(a_sel, 8'hff);
			wr(a_ctl, 8'hc0);
		end
		do rd(a_ctl); while (rd_v[4] !== 1'b1);
		`CHK(rd_v[7:0], {6'h2c, ex[1:0]})
		rd(a_res);
		`CHK(rd_v, {24'h0, ex[9:2]})
		`CHK(conv_irq, 1'b1)
		wr(a_ctl, 8'h80);
		rd(a_ctl);
		`CHK(rd_v[4], 1'b0)
		`CHK(conv_irq, 1'b0)
		wr(ga, 8'hff);
		$display("conversion code %0d channel %0d done", c, ch);
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Reset values, refused places, then every divider code and group
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		wr(a_res, 8'h5a);
		`CHK(wr_r, `RESP_OKAY)
		wr(12'h220, 8'h55);
		`CHK(wr_r, `RESP_SLVERR)
		// Lane 0 strobe low: the write is answered but must not land
		s_axi_wstrb <= 4'he;
		wr(a_sel, 8'h77);
		s_axi_wstrb <= 4'hf;
		`CHK(wr_r, `RESP_OKAY)
		for (int i = 0; i < 9; i++) begin
			rd(ra[i]);
			`CHK(rd_v, {24'h0, rv[i]})
		end
		`CHK(rd_r, `RESP_SLVERR)
		// Request without enable must not start: done stays high
		wr(a_ctl, 8'h40);
		rd(a_ctl);
		`CHK(rd_v, 32'h00000060)
		wr(a_ctl, 8'h00);
		$display("reset values done");
		wr(a_irq, 8'h01);
		for (int i = 0; i < 8; i++) conv(i[2:0], 5'(i * 5), lv[i], 1'b1, 1'b0);
		conv(3'h0, 5'h09, 10'h2c3, 1'b1, 1'b1);
		conv(3'h0, 5'h12, 10'h2c3, 1'b0, 1'b0);
		end_of_test;
	end
endmodule // sar_adc_ctrl_bench
